// ===== logic/evpd_map.svh
// Register offsets, field positions, reset values and vector constants
`ifndef EVPD_MAP_SVH
`define EVPD_MAP_SVH

// Word indices; byte address is four times the index
`define EVPD_IDX_CTRL 6'h15
`define EVPD_IDX_TEST 6'h16
`define EVPD_IDX_PROMO 6'h17

// Test control fields
`define EVPD_CTRL_WEN_BIT 4
`define EVPD_CTRL_SEL_MSB 3
`define EVPD_CTRL_SEL_LSB 0
`define EVPD_RST_WEN 1'h0
`define EVPD_RST_SEL 4'hf

// Test bits reset value
`define EVPD_RST_TEST 32'h0000_0000

// Promotion select: bits 7..1 hold the vector low byte
`define EVPD_RST_PROMO 7'h79
`define EVPD_PROMO_LOW 8'hc0
`define EVPD_PROMO_HIGH 8'hf2

// Implemented test groups: lowest group nibble and top group nibble
`define EVPD_GRP_LOW 4'hc
`define EVPD_GRP_TOP 4'hf
`define EVPD_TOP_MASK 8'h07

// Request vector positions
`define EVPD_IDX_PIN 5'h19
`define EVPD_IDX_XPIN 26

// Exception vectors
`define EVPD_VEC_POR 16'hfffe
`define EVPD_VEC_CLKMON 16'hfffc
`define EVPD_VEC_WDOG 16'hfffa
`define EVPD_VEC_TRAP 16'hfff8
`define EVPD_VEC_SWI 16'hfff6
`define EVPD_VEC_XPIN 16'hfff4
`define EVPD_VEC_PAGE 8'hff

`endif

// ===== logic/evpd_pkg.sv
// Types shared by the exception vector priority decoder
package evpd_pkg;
  typedef logic [15:0] evpd_vec_t;
  typedef logic [31:0] evpd_req_t;
  typedef logic [4:0] evpd_idx_t;
endpackage

// ===== logic/evpd_decoder.sv
// Exception vector priority decoder with test and promotion registers
// How it works
// [R1] Test enable drives decoder from test bits
// [R2] Test enable writable: special mode, I and X
// [R3] Test enable clear: writes ignored, reads live
// [R4] Pending requests copied into test bits
// [R5] Four-bit select picks test register group
// [R6] Test reads zero in normal modes
// [R7] Test writes need special, enable, I mask
// [R8] Bit n forces vector low nibble 2n
// [R9] One test register per eight requests
// [R10] Top group exposes only bits 2..0
// [R11] Unimplemented group: writes ignored, reads zero
// [R12] Promotion register writable only with I mask
// [R13] Promotion byte selects highest I source
// [R14] Invalid promotion falls back to pin request
// [R15] Active promoted request wins among I sources
// [R16] Priority evaluated when CPU asks vector
// [R17] Vanished request gives last valid vector
// [R18] Never pending gives software trap vector
// [R19] Three reset requests give reset vectors
// [R20] Fixed priority resets, trap, soft, pins, peripherals
// [R21] Sources hold requests until service starts
// [R22] Pin levels come from bus interface
// [R23] Asynchronous wake on valid or nonmaskable pin
// [R24] Pending signal honours I and X masks
`include "evpd_map.svh"

module evpd_decoder (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic special_mode,
  input wire logic i_mask,
  input wire logic x_mask,
  input wire logic maskable_pin_n,
  input wire logic nonmaskable_pin_request_n,
  input wire logic [24:0] periph_req,
  input wire logic por_req,
  input wire logic clkmon_req,
  input wire logic watchdog_reset,
  input wire logic trap_req,
  input wire logic debug_request,
  input wire logic vec_req,
  output logic [15:0] vector,
  output logic vector_valid,
  output logic int_pending,
  output logic wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Highest set request among the I-maskable positions
  function automatic evpd_pkg::evpd_idx_t top_index(input logic [25:0] req);
    evpd_pkg::evpd_idx_t idx;
    idx = 5'h00;
    for (int k = 0; k < 26; k++) begin
      if (req[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  // Position in the request vector to full vector address
  function automatic evpd_pkg::evpd_vec_t idx_vec(
    input evpd_pkg::evpd_idx_t idx);
    logic [7:0] low;
    low = 8'(`EVPD_PROMO_LOW + {2'h0, idx, 1'b0});
    return {`EVPD_VEC_PAGE, low};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] pin_sync_ff;
  logic [1:0] xpin_sync_ff;
  logic wen_ff;
  logic [3:0] sel_ff;
  evpd_pkg::evpd_req_t test_ff;
  logic [6:0] promo_ff;
  logic seen_ff;
  evpd_pkg::evpd_vec_t last_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  evpd_pkg::evpd_vec_t vector_ff;
  logic vector_valid_ff;
  logic int_pending_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Pins come from the bus interface but are still outside levels
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_sync_ff <= 2'h3;
      xpin_sync_ff <= 2'h3;
    end else if (clock_en) begin
      pin_sync_ff <= {pin_sync_ff[0], maskable_pin_n}; // R22
      xpin_sync_ff <= {xpin_sync_ff[0], nonmaskable_pin_request_n}; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live and decoder request vectors
  // Group C..E are peripherals, group F holds FFF0, pin, nonmaskable pin
  wire evpd_pkg::evpd_req_t live_req;
  wire evpd_pkg::evpd_req_t dec_req;
  assign live_req = {5'h00, ~xpin_sync_ff[1], ~pin_sync_ff[1], periph_req};
  assign dec_req = wen_ff ? test_ff : live_req; // R1

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [5:0] word_idx;
  wire bus_req;
  wire bus_take;
  wire hit_ctrl;
  wire hit_test;
  wire hit_promo;
  wire wr_ok;
  assign word_idx = address[7:2];
  assign bus_req = read | write;
  // Write data takes effect on the edge with waitrequest low; read data is loaded on the edge before
  assign bus_take = bus_req & ~wait_ff;
  assign hit_ctrl = word_idx == `EVPD_IDX_CTRL;
  assign hit_test = word_idx == `EVPD_IDX_TEST;
  assign hit_promo = word_idx == `EVPD_IDX_PROMO;
  assign wr_ok = write & bus_take & byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // Test group selection
  // Only groups C..F exist; any other select is unimplemented
  wire grp_ok;
  wire grp_top;
  wire [1:0] grp_off;
  wire [7:0] grp_mask;
  wire [7:0] grp_live;
  wire [7:0] grp_test;
  assign grp_ok = sel_ff >= `EVPD_GRP_LOW; // R9 R11
  assign grp_top = sel_ff == `EVPD_GRP_TOP;
  assign grp_off = 2'(sel_ff - `EVPD_GRP_LOW); // R5
  assign grp_mask = grp_top ? `EVPD_TOP_MASK : 8'hff; // R10
  assign grp_live = live_req[{grp_off, 3'h0} +: 8];
  assign grp_test = test_ff[{grp_off, 3'h0} +: 8];

  // Reads: zero in normal modes, live or forced in special modes
  wire [7:0] test_rd;
  assign test_rd = (special_mode && grp_ok) ? // R6 R11
    ((wen_ff ? grp_test : grp_live) & grp_mask) : 8'h00; // R3 R10

  ////////////////////////////////////////////////////////////////////////////
  // Register write qualifiers
  wire ctrl_wr;
  wire wen_wr;
  wire test_wr;
  wire promo_wr;
  assign ctrl_wr = wr_ok & hit_ctrl;
  assign wen_wr = ctrl_wr & special_mode & i_mask & x_mask; // R2
  // Forced writes need the test enable already set
  assign test_wr = wr_ok & hit_test & special_mode & wen_ff & i_mask &
    grp_ok; // R7 R3 R11
  assign promo_wr = wr_ok & hit_promo & i_mask; // R12

  // Next test bits; entering test mode captures what is pending now
  wire [7:0] test_grp_new;
  evpd_pkg::evpd_req_t nxt_test;
  assign test_grp_new = writedata[7:0] & grp_mask; // R8 R10
  always_comb begin
    nxt_test = test_ff;
    if (wen_wr && writedata[`EVPD_CTRL_WEN_BIT] && !wen_ff) begin
      nxt_test = live_req; // R4
    end else if (test_wr) begin
      nxt_test[{grp_off, 3'h0} +: 8] = test_grp_new; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, test and promotion registers
  // Select is free to change; enable is guarded
  always_ff @(posedge clock) begin
    if (reset) begin
      wen_ff <= `EVPD_RST_WEN;
      sel_ff <= `EVPD_RST_SEL;
    end else if (clock_en) begin
      if (ctrl_wr) begin
        sel_ff <= writedata[`EVPD_CTRL_SEL_MSB:`EVPD_CTRL_SEL_LSB]; // R5
      end
      if (wen_wr) begin
        wen_ff <= writedata[`EVPD_CTRL_WEN_BIT]; // R2
      end
    end
  end

  // Test bits hold after the enable falls, unused by the decoder then
  always_ff @(posedge clock) begin
    if (reset) begin
      test_ff <= `EVPD_RST_TEST;
    end else if (clock_en) begin
      test_ff <= nxt_test;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      promo_ff <= `EVPD_RST_PROMO;
    end else if (clock_en && promo_wr) begin
      promo_ff <= writedata[7:1]; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Promotion and priority
  // Out-of-range or non-I promotion falls back to the maskable pin
  wire [7:0] promo_byte;
  wire promo_ok;
  wire evpd_pkg::evpd_idx_t promo_idx;
  assign promo_byte = {promo_ff, 1'b0};
  assign promo_ok = promo_byte >= `EVPD_PROMO_LOW &&
    promo_byte <= `EVPD_PROMO_HIGH; // R14
  assign promo_idx = promo_ok ?
    5'((promo_byte - `EVPD_PROMO_LOW) >> 1) : `EVPD_IDX_PIN; // R13 R14

  // Valid requests are those their mask lets through
  wire [25:0] i_req;
  wire x_valid;
  wire promo_act;
  wire evpd_pkg::evpd_idx_t i_idx;
  wire int_valid;
  wire evpd_pkg::evpd_vec_t int_vec;
  assign i_req = dec_req[25:0] & {26{~i_mask}}; // R24
  assign x_valid = dec_req[`EVPD_IDX_XPIN] & ~x_mask; // R24
  assign promo_act = i_req[promo_idx]; // R15
  assign i_idx = promo_act ? promo_idx : top_index(i_req); // R15 R20
  assign int_valid = x_valid | (|i_req);
  assign int_vec = x_valid ? `EVPD_VEC_XPIN : idx_vec(i_idx); // R20

  // Vector chosen at the moment of the request, not earlier
  evpd_pkg::evpd_vec_t nxt_vector;
  always_comb begin
    if (por_req) begin
      nxt_vector = `EVPD_VEC_POR; // R19 R20
    end else if (clkmon_req) begin
      nxt_vector = `EVPD_VEC_CLKMON; // R19
    end else if (watchdog_reset) begin
      nxt_vector = `EVPD_VEC_WDOG; // R19
    end else if (trap_req) begin
      nxt_vector = `EVPD_VEC_TRAP; // R20
    end else if (debug_request) begin
      nxt_vector = `EVPD_VEC_SWI; // R20
    end else if (int_valid) begin
      nxt_vector = int_vec; // R16
    end else if (seen_ff) begin
      nxt_vector = last_ff; // R17
    end else begin
      nxt_vector = `EVPD_VEC_SWI; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence memory
  // Tracks the last valid interrupt; only reset clears it, a served vector does not
  always_ff @(posedge clock) begin
    if (reset) begin
      seen_ff <= 1'b0;
      last_ff <= `EVPD_VEC_SWI;
    end else if (clock_en) begin
      if (int_valid) begin
        seen_ff <= 1'b1; // R17
        last_ff <= int_vec; // R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU answers
  // Vector answered one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      vector_ff <= `EVPD_VEC_POR;
      vector_valid_ff <= 1'b0;
      int_pending_ff <= 1'b0;
    end else if (clock_en) begin
      vector_valid_ff <= vec_req;
      if (vec_req) begin
        vector_ff <= nxt_vector; // R16
      end
      int_pending_ff <= int_valid; // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  // Every access takes exactly one wait cycle
  wire nxt_wait;
  logic [31:0] nxt_rdata;
  assign nxt_wait = ~(bus_req & wait_ff);
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata[`EVPD_CTRL_WEN_BIT] = wen_ff;
      nxt_rdata[`EVPD_CTRL_SEL_MSB:`EVPD_CTRL_SEL_LSB] = sel_ff;
    end else if (hit_test) begin
      nxt_rdata[7:0] = test_rd; // R6
    end else if (hit_promo) begin
      nxt_rdata[7:0] = promo_byte; // R12
    end
  end

  // Read data loaded in the wait cycle, standing when waitrequest drops
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (clock_en) begin
      wait_ff <= nxt_wait;
      if (read && wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign vector = vector_ff;
  assign vector_valid = vector_valid_ff;
  assign int_pending = int_pending_ff;

  // Wake path must work with the clock stopped, so it is gate-only
  assign wake = ((|periph_req | ~maskable_pin_n) & ~i_mask) |
    ~nonmaskable_pin_request_n; // R23

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_bus_first;
    bus_req && wait_ff && clock_en;
  endsequence
  sequence s_vec_ask;
    vec_req && clock_en;
  endsequence
  a_bus_one_wait: assert property (
    s_bus_first |=> !waitrequest)
    else $error("bus answer not after one wait cycle");
  a_vec_answer_timing: assert property ( // R16
    s_vec_ask |=> vector_valid && vector == $past(nxt_vector))
    else $error("vector not answered next cycle");
  a_vec_reset_top: assert property ( // R19
    s_vec_ask and por_req |=> vector == 16'hfffe)
    else $error("power-on reset vector wrong");
  a_vec_soft_default: assert property ( // R18
    s_vec_ask and (!por_req && !clkmon_req && !watchdog_reset &&
      !trap_req && !debug_request && !int_valid && !seen_ff)
    |=> vector == 16'hfff6)
    else $error("default vector not software trap");
  a_test_write_guard: assert property ( // R3
    (clock_en && wr_ok && hit_test && !wen_ff) |=> $stable(test_ff))
    else $error("test bits changed while disabled");
  a_wen_mode_guard: assert property ( // R2
    (clock_en && ctrl_wr && (!special_mode || !i_mask || !x_mask))
    |=> $stable(wen_ff))
    else $error("test enable written outside guard");
  a_promo_guard: assert property ( // R12
    (clock_en && promo_wr == 1'b0 && wr_ok && hit_promo)
    |=> $stable(promo_ff))
    else $error("promotion changed with I mask clear");
  a_normal_read_zero: assert property ( // R6
    (s_bus_first and (read && hit_test && !special_mode))
    |=> readdata == 32'h0000_0000)
    else $error("test read not zero in normal mode");
  a_pending_masked: assert property ( // R24
    (clock_en && i_mask && x_mask) |=> !int_pending)
    else $error("pending raised while fully masked");
  a_promo_wins: assert property ( // R15
    (s_vec_ask and (promo_act && !x_valid && !por_req && !clkmon_req &&
      !watchdog_reset && !trap_req && !debug_request))
    |=> vector == $past(idx_vec(promo_idx)))
    else $error("promoted request did not win");
  a_top_group_mask: assert property ( // R10
    (s_bus_first and (read && hit_test && grp_top))
    |=> readdata[7:3] == 5'h00)
    else $error("top group upper bits not zero");
endmodule

// ===== test/evpd_cpu_model.sv
// CPU-side model that asks for vectors and keeps each answer
module evpd_cpu_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic ask,
  input wire logic slow,
  output logic vec_req,
  input wire logic [15:0] vector,
  input wire logic vector_valid,
  output logic got,
  output logic [15:0] got_vec
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] dly_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Slow asks leave a gap in which a later request may overtake
  always_ff @(posedge clock) begin
    vec_req <= !reset && dly_ff == 3'h1;
    got <= !reset && vector_valid;
    if (reset) begin
      dly_ff <= 3'h0;
    end else begin
      if (ask) begin
        dly_ff <= slow ? 3'h4 : 3'h1;
      end else if (dly_ff != 3'h0) begin
        dly_ff <= dly_ff - 3'h1;
      end
      if (vector_valid) begin
        got_vec <= vector;
      end
    end
  end
endmodule

// ===== test/evpd_decoder_tb_top.sv
// Self-checking bench for the exception vector priority decoder
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module evpd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, clock_en, read, write, waitrequest;
  logic special_mode, i_mask, x_mask, maskable_pin_n;
  logic nonmaskable_pin_request_n, por_req, clkmon_req, watchdog_reset;
  logic trap_req, debug_request, vec_req, vector_valid, int_pending, wake;
  logic ask, slow, got;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic [24:0] periph_req;
  logic [15:0] vector, got_vec;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  evpd_decoder evpd_decoder_i (.clock, .reset, .clock_en, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .special_mode,
    .i_mask, .x_mask, .maskable_pin_n, .nonmaskable_pin_request_n,
    .periph_req, .por_req, .clkmon_req, .watchdog_reset, .trap_req,
    .debug_request, .vec_req, .vector, .vector_valid, .int_pending, .wake);
  evpd_cpu_model evpd_cpu_model_i (.clock, .reset, .ask, .slow, .vec_req,
    .vector, .vector_valid, .got, .got_vec);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a ceiling on run length, so a hang still gets a verdict
  initial clock = 1'b0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Avalon access: request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask

  // Ask the CPU model for a vector and compare the answer
  task automatic vc(input logic [15:0] e);
    ask <= 1'b1;
    @(posedge clock);
    ask <= 1'b0;
    do begin
      @(posedge clock);
    end while (got !== 1'b1);
    `CHK(got_vec, e)
  endtask

  // Requests held until the next call; extra edges cover the pin synchroniser
  task automatic sr(input logic [31:0] r);
    periph_req <= r[24:0];
    maskable_pin_n <= !r[25];
    nonmaskable_pin_request_n <= !r[26];
    debug_request <= r[27];
    trap_req <= r[28];
    watchdog_reset <= r[29];
    clkmon_req <= r[30];
    por_req <= r[31];
    repeat (3) @(posedge clock);
  endtask

  // Expected vector when bit k is the highest request
  function automatic logic [15:0] ev(input int k);
    case (k)
      31: ev = 16'hfffe;
      30: ev = 16'hfffc;
      29: ev = 16'hfffa;
      28: ev = 16'hfff8;
      27: ev = 16'hfff6;
      26: ev = 16'hfff4;
      25: ev = 16'hfff2;
      default: ev = 16'hffc0 + 16'(2 * k);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_idle;
    rd(8'h54, 8'h0f);
    rd(8'h58, 8'h00);
    rd(8'h5c, 8'hf2);
    rd(8'h60, 8'h00);
    vc(16'hfff6);
    $display("test idle done");
  endtask

  task automatic t_prio;
    i_mask <= 1'b0;
    x_mask <= 1'b0;
    for (int k = 31; k >= 0; k--) begin
      sr(32'hffff_ffff >> (31 - k));
      vc(ev(k));
    end
    $display("test prio done");
  endtask

  task automatic t_mask;
    i_mask <= 1'b1;
    x_mask <= 1'b1;
    sr(32'h0000_0008);
    `CHK(int_pending, 1'b0)
    `CHK(wake, 1'b0)
    // Clock enable low must freeze the pending flag
    clock_en <= 1'b0;
    i_mask <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(int_pending, 1'b0)
    clock_en <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(int_pending, 1'b1)
    `CHK(wake, 1'b1)
    i_mask <= 1'b1;
    sr(32'h0400_0000);
    `CHK(int_pending, 1'b0)
    `CHK(wake, 1'b1)
    x_mask <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(int_pending, 1'b1)
    i_mask <= 1'b0;
    x_mask <= 1'b1;
    sr(32'h0000_0020);
    sr(32'h0000_0000);
    vc(16'hffca);
    slow <= 1'b1;
    sr(32'h0000_0020);
    fork
      begin
        repeat (2) @(posedge clock);
        trap_req <= 1'b1;
      end
    join_none
    vc(16'hfff8);
    slow <= 1'b0;
    sr(32'h0000_0000);
    $display("test mask done");
  endtask

  task automatic t_promo;
    i_mask <= 1'b0;
    wr(8'h5c, 8'hd0);
    rd(8'h5c, 8'hf2);
    i_mask <= 1'b1;
    wr(8'h5c, 8'hd1);
    rd(8'h5c, 8'hd0);
    i_mask <= 1'b0;
    sr(32'h0210_0100);
    vc(16'hffd0);
    sr(32'h0010_0000);
    vc(16'hffe8);
    i_mask <= 1'b1;
    wr(8'h5c, 8'hf4);
    i_mask <= 1'b0;
    sr(32'h0300_0000);
    vc(16'hfff2);
    $display("test promo done");
  endtask

  task automatic t_test;
    special_mode <= 1'b0;
    i_mask <= 1'b1;
    x_mask <= 1'b1;
    sr(32'h0100_0000);
    wr(8'h54, 8'h1c);
    rd(8'h54, 8'h0c);
    rd(8'h58, 8'h00);
    special_mode <= 1'b1;
    x_mask <= 1'b0;
    wr(8'h54, 8'h1f);
    rd(8'h54, 8'h0f);
    rd(8'h58, 8'h01);
    wr(8'h58, 8'h02);
    rd(8'h58, 8'h01);
    x_mask <= 1'b1;
    wr(8'h54, 8'h1f);
    rd(8'h54, 8'h1f);
    rd(8'h58, 8'h01);
    sr(32'h0000_0000);
    rd(8'h58, 8'h01);
    wr(8'h58, 8'hff);
    rd(8'h58, 8'h07);
    i_mask <= 1'b0;
    wr(8'h58, 8'h00);
    rd(8'h58, 8'h07);
    vc(16'hfff2);
    i_mask <= 1'b1;
    wr(8'h58, 8'h00);
    wr(8'h54, 8'h1e);
    wr(8'h58, 8'h80);
    i_mask <= 1'b0;
    sr(32'h0000_0001);
    vc(16'hffee);
    i_mask <= 1'b1;
    wr(8'h54, 8'h17);
    wr(8'h58, 8'hff);
    rd(8'h58, 8'h00);
    wr(8'h54, 8'h1c);
    wr(8'h58, 8'h01);
    rd(8'h58, 8'h01);
    special_mode <= 1'b0;
    rd(8'h58, 8'h00);
    $display("test testregs done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; byteenable stays fixed throughout
  initial begin
    {reset, read, write, ask, slow, special_mode} = 6'h21;
    {clock_en, i_mask, x_mask} = 3'h7;
    {maskable_pin_n, nonmaskable_pin_request_n} = 2'h3;
    {por_req, clkmon_req, watchdog_reset, trap_req, debug_request} = 5'h00;
    address = 8'h00;
    byteenable = 4'h1;
    writedata = 32'h0000_0000;
    periph_req = 25'h000_0000;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_idle;
    t_prio;
    t_mask;
    t_promo;
    t_test;
    stop_test;
  end
endmodule
